// ==== rtl/sai_pkg.sv ====
/*
 * Shared constants of the serial converter interface: control byte layout,
 * mode and shutdown level codes, and conversion timing.
 * Assumes a 40 MHz system clock that also stands in for the internal
 * conversion oscillator.
 */
package sai_pkg;

    // ************************************************************
    // Sizes and control byte layout
    // ************************************************************
    localparam int RESULT_BITS = 12;
    localparam int CTRL_BITS = 8;
    localparam logic [3:0] START_COUNT = 4'h1;
    localparam logic [3:0] TRACK_COUNT = 4'h5;
    localparam logic [3:0] HOLD_COUNT = 4'h8;
    localparam int CH_MSB = 6;
    localparam int CH_MID = 5;
    localparam int CH_LSB = 4;
    localparam int POL_POS = 3;
    localparam int TYPE_POS = 2;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;

    // ************************************************************
    // Mode and level codes
    // ************************************************************
    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;
    localparam logic [1:0] SD_LEVEL_LOW = 2'h0;
    localparam logic [1:0] SD_LEVEL_FLOAT = 2'h1;
    localparam logic [1:0] SD_LEVEL_HIGH = 2'h2;
    localparam logic [1:0] SD_LEVEL_ALT_HIGH = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int INT_BIT_TIME_NS = 100;
    localparam int INT_BIT_CYCLES =
        (INT_BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DUTY_NOMINAL_PCT = 50;
    localparam int DUTY_MIN_PCT = 40;
    localparam int DUTY_MAX_PCT = 60;

endpackage

// ==== rtl/sai_sync3.sv ====
/*
 * Three-stage synchroniser with agreement filter, one lane per bit.
 * Assumes each input bit changes slowly compared with the clock.
 */
module sai_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;

    assign q = q_reg;

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_lane
        // A change is taken only once the last two stages agree
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                s1_reg[i] <= RESET_VALUE[i];
                s2_reg[i] <= RESET_VALUE[i];
                s3_reg[i] <= RESET_VALUE[i];
                q_reg[i] <= RESET_VALUE[i];
            end
            else
            begin
                s1_reg[i] <= d[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i])
                begin
                    q_reg[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule // sai_sync3

// ==== rtl/sai_sar_engine.sv ====
/*
 * Successive-approximation register: holds the trial code for the DAC.
 * Assumes comp_high is settled when step is sampled and is high when
 * the input lies above the present trial code.
 */
module sai_sar_engine #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic step,
    input wire logic comp_high,
    // Trial code
    output logic [WIDTH-1:0] code
);

    localparam logic [WIDTH-1:0] TOP_ONE = {1'b1, {(WIDTH - 1){1'b0}}};

    logic [WIDTH-1:0] code_reg;
    logic [WIDTH-1:0] probe_reg;

    assign code = code_reg;

    // Probe marks the bit under decision; it drains to zero after the LSB
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_reg <= '0;
            probe_reg <= '0;
        end
        else if (start)
        begin
            code_reg <= TOP_ONE;
            probe_reg <= TOP_ONE;
        end
        else if (step)
        begin
            code_reg <= (code_reg & ~probe_reg)
                | (comp_high ? probe_reg : '0) | (probe_reg >> 1);
            probe_reg <= probe_reg >> 1;
        end
    end

endmodule // sai_sar_engine

// ==== rtl/sai_serial_adc_interface.sv ====
/*
 * Serial interface and conversion sequencing of an eight-channel 12-bit
 * successive-approximation converter.
 * Assumes an analog front end that follows the sampler, channel and DAC
 * outputs, a level detector that codes the shutdown pin on two bits, and
 * a host that keeps its side of the serial protocol.
 */
// Behaviour
// - Each result bit is put on the data output at a falling serial edge.
// - The data output floats while chip select is high.
// - The data input is sampled on rising serial edges up to the eighth control bit, then again once the sequencer is idle.
// - Nothing is shifted in unless chip select is low.
// - Internal clock mode drives the strobe low at start, high when done.
// - External clock mode pulses the strobe high one period before the MSB.
// - External clock mode floats the strobe while chip select is high.
// - Conversion time is clock cycles times the clock period.
// - A low shutdown level shuts down; any other level is operational.
// - High shutdown level picks internal compensation, floating external.
// - The sampler tracks from the falling edge after control bit five.
// - The sampler holds from the falling edge after control bit eight.
// - Bit 3 is polarity, bit 2 input type, bits 6 to 4 the channel.
module sai_serial_adc_interface
    import sai_pkg::*;
#(
    parameter int RESULT_WIDTH = sai_pkg::RESULT_BITS,
    parameter int BIT_CYCLES = sai_pkg::INT_BIT_CYCLES
) (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe,
    output logic conversion_strobe_oe,
    // Shutdown level code from the pin detector
    input wire logic [1:0] three_level_shutdown,
    output logic device_shutdown,
    output logic internal_compensation,
    // Analog front end
    input wire logic comparator_high,
    output logic sampler_track,
    output logic channel_select_bit2,
    output logic channel_select_bit1,
    output logic channel_select_bit0,
    output logic polarity_select,
    output logic input_type_select,
    output logic power_clock_mode_hi,
    output logic power_clock_mode_lo,
    output logic [RESULT_WIDTH-1:0] dac_code_link,
    output logic [RESULT_WIDTH-1:0] dac_code_osc
);

    import sai_pkg::*;

    if (RESULT_WIDTH < 2 || RESULT_WIDTH > 15)
    begin : g_bad_width
        $error("RESULT_WIDTH must lie between 2 and 15");
    end
    if (BIT_CYCLES < 1 || BIT_CYCLES > 255)
    begin : g_bad_cycles
        $error("BIT_CYCLES must lie between 1 and 255");
    end

    localparam logic [3:0] IDX_MSB = 4'(RESULT_WIDTH - 1);
    localparam logic [3:0] IDX_NEXT = 4'(RESULT_WIDTH - 2);
    localparam logic [7:0] CYCLE_LAST = 8'(BIT_CYCLES - 1);
    localparam logic [4:0] SYNC_RESET = {1'b1, SD_LEVEL_FLOAT, 2'h0};

    typedef enum {
        NEG_IDLE, NEG_ACQ, NEG_STROBE, NEG_CONV_EXT,
        NEG_WAIT_INT, NEG_READ_INT, NEG_DONE
    } sai_neg_state_type;
    typedef enum {INT_IDLE, INT_CONV, INT_FINISH} sai_int_state_type;

    function automatic logic mode_is_ext(input logic [1:0] mode);
        return mode == MODE_EXT_CLK;
    endfunction

    function automatic logic mode_converts(input logic [1:0] mode);
        return mode == MODE_INT_CLK || mode == MODE_EXT_CLK;
    endfunction

    // ************************************************************
    // Serial clock domain: control byte reception
    // ************************************************************
    logic link_rst_n;
    logic sclk_n;
    logic [3:0] rx_count_reg;
    logic [CTRL_BITS-2:0] rx_shift_reg;
    logic neg_busy_reg;
    logic [CTRL_BITS-1:0] ctrl_byte;
    logic [1:0] ctrl_mode;
    logic byte_done;
    logic hold_now;

    // Chip select high clears the link logic, so a partial byte is dropped
    assign link_rst_n = rst_n & ~cs_n;
    assign sclk_n = ~sclk;
    assign ctrl_byte = {1'b1, rx_shift_reg};
    assign ctrl_mode = ctrl_byte[MODE_MSB:MODE_LSB];
    assign byte_done = rx_count_reg == HOLD_COUNT;

    always_ff @(posedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rx_count_reg <= '0;
            rx_shift_reg <= '0;
        end
        else if (neg_busy_reg)
        begin
            rx_count_reg <= '0;
        end
        else if (rx_count_reg == '0)
        begin
            if (din)
            begin
                rx_count_reg <= START_COUNT;
            end
        end
        else if (!byte_done)
        begin
            rx_shift_reg <= {rx_shift_reg[CTRL_BITS-3:0], din};
            rx_count_reg <= rx_count_reg + 4'h1;
        end
    end

    // ************************************************************
    // Serial clock domain: falling-edge sequencer
    // ************************************************************
    sai_neg_state_type neg_state_reg;
    logic [3:0] bit_idx_reg;
    logic ext_strobe_reg;
    logic dout_reg;
    logic track_reg;
    logic start_toggle_reg;
    logic sar_link_start;
    logic sar_link_step;
    logic [RESULT_WIDTH-1:0] int_result_reg;

    assign hold_now = neg_state_reg == NEG_ACQ && byte_done;
    assign sar_link_start = hold_now && mode_is_ext(ctrl_mode);
    // The host clock itself steps the external conversion
    assign sar_link_step = neg_state_reg == NEG_STROBE
        || neg_state_reg == NEG_CONV_EXT;

    always_ff @(negedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            neg_state_reg <= NEG_IDLE;
            bit_idx_reg <= '0;
            ext_strobe_reg <= 1'b0;
            dout_reg <= 1'b0;
            track_reg <= 1'b0;
            neg_busy_reg <= 1'b0;
        end
        else
        begin
            case (neg_state_reg)
                NEG_IDLE:
                begin
                    dout_reg <= 1'b0;
                    if (rx_count_reg == TRACK_COUNT)
                    begin
                        track_reg <= 1'b1;
                        neg_state_reg <= NEG_ACQ;
                    end
                end
                NEG_ACQ:
                begin
                    if (byte_done)
                    begin
                        track_reg <= 1'b0;
                        neg_busy_reg <= 1'b1;
                        if (!mode_converts(ctrl_mode))
                        begin
                            neg_state_reg <= NEG_DONE;
                        end
                        else if (mode_is_ext(ctrl_mode))
                        begin
                            ext_strobe_reg <= 1'b1;
                            neg_state_reg <= NEG_STROBE;
                        end
                        else
                        begin
                            neg_state_reg <= NEG_WAIT_INT;
                        end
                    end
                end
                NEG_STROBE:
                begin
                    ext_strobe_reg <= 1'b0;
                    dout_reg <= comparator_high;
                    bit_idx_reg <= IDX_NEXT;
                    neg_state_reg <= NEG_CONV_EXT;
                end
                NEG_CONV_EXT:
                begin
                    dout_reg <= comparator_high;
                    bit_idx_reg <= bit_idx_reg - 4'h1;
                    if (bit_idx_reg == '0)
                    begin
                        neg_busy_reg <= 1'b0;
                        neg_state_reg <= NEG_IDLE;
                    end
                end
                NEG_WAIT_INT:
                begin
                    // The result is stable here: the host waited for the
                    // strobe before clocking again
                    dout_reg <= int_result_reg[IDX_MSB];
                    bit_idx_reg <= IDX_NEXT;
                    neg_state_reg <= NEG_READ_INT;
                end
                NEG_READ_INT:
                begin
                    dout_reg <= int_result_reg[bit_idx_reg];
                    bit_idx_reg <= bit_idx_reg - 4'h1;
                    if (bit_idx_reg == '0)
                    begin
                        neg_busy_reg <= 1'b0;
                        neg_state_reg <= NEG_IDLE;
                    end
                end
                NEG_DONE:
                begin
                    neg_busy_reg <= 1'b0;
                    neg_state_reg <= NEG_IDLE;
                end
                default:
                begin
                    neg_state_reg <= NEG_IDLE;
                end
            endcase
        end
    end

    // Survives chip select so the oscillator side never sees a false start
    always_ff @(negedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_toggle_reg <= 1'b0;
        end
        else if (hold_now && ctrl_mode == MODE_INT_CLK)
        begin
            start_toggle_reg <= ~start_toggle_reg;
        end
    end

    // ************************************************************
    // Configuration latched at hold
    // ************************************************************
    logic [2:0] chan_reg;
    logic pol_reg;
    logic type_reg;
    logic [1:0] mode_reg;
    logic mode_ext_reg;

    always_ff @(negedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_reg <= '0;
            pol_reg <= 1'b0;
            type_reg <= 1'b0;
            mode_reg <= MODE_FULL_PD;
            mode_ext_reg <= 1'b0;
        end
        else if (hold_now && !cs_n)
        begin
            chan_reg <= ctrl_byte[CH_MSB:CH_LSB];
            pol_reg <= ctrl_byte[POL_POS];
            type_reg <= ctrl_byte[TYPE_POS];
            mode_reg <= ctrl_mode;
            mode_ext_reg <= mode_is_ext(ctrl_mode);
        end
    end

    sai_sar_engine #(
        .WIDTH(RESULT_WIDTH)
    ) u_sar_link (
        .clk(sclk_n),
        .rst_n(link_rst_n),
        .start(sar_link_start),
        .step(sar_link_step),
        .comp_high(comparator_high),
        .code(dac_code_link)
    );

    // ************************************************************
    // System clock domain: crossings, enables and shutdown
    // ************************************************************
    logic [4:0] sync_q;
    logic sync_cs_n;
    logic [1:0] sync_sd;
    logic sync_toggle;
    logic sync_ext;
    logic toggle_seen_reg;
    logic start_evt;
    logic dout_oe_reg;
    logic strobe_oe_reg;
    logic shutdown_reg;
    logic int_comp_reg;

    sai_sync3 #(
        .WIDTH(5),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({cs_n, three_level_shutdown, start_toggle_reg, mode_ext_reg}),
        .q(sync_q)
    );

    assign sync_cs_n = sync_q[4];
    assign sync_sd = sync_q[3:2];
    assign sync_toggle = sync_q[1];
    assign sync_ext = sync_q[0];
    assign start_evt = sync_toggle != toggle_seen_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            toggle_seen_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
            strobe_oe_reg <= 1'b1;
            shutdown_reg <= 1'b0;
            int_comp_reg <= 1'b0;
        end
        else
        begin
            toggle_seen_reg <= sync_toggle;
            dout_oe_reg <= ~sync_cs_n;
            strobe_oe_reg <= ~(sync_ext & sync_cs_n);
            shutdown_reg <= sync_sd == SD_LEVEL_LOW;
            int_comp_reg <= sync_sd == SD_LEVEL_HIGH
                || sync_sd == SD_LEVEL_ALT_HIGH;
        end
    end

    // ************************************************************
    // System clock domain: internal-clock conversion
    // ************************************************************
    sai_int_state_type int_state_reg;
    logic [3:0] int_bit_reg;
    logic [7:0] int_cycle_reg;
    logic int_strobe_reg;
    logic sar_osc_start;
    logic sar_osc_step;

    assign sar_osc_start = int_state_reg == INT_IDLE && start_evt
        && !shutdown_reg;
    assign sar_osc_step = int_state_reg == INT_CONV && !shutdown_reg
        && int_cycle_reg == CYCLE_LAST;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_state_reg <= INT_IDLE;
            int_bit_reg <= '0;
            int_cycle_reg <= '0;
            int_strobe_reg <= 1'b1;
            int_result_reg <= '0;
        end
        else
        begin
            case (int_state_reg)
                INT_IDLE:
                begin
                    if (sar_osc_start)
                    begin
                        int_strobe_reg <= 1'b0;
                        int_cycle_reg <= '0;
                        int_bit_reg <= IDX_MSB;
                        int_state_reg <= INT_CONV;
                    end
                end
                INT_CONV:
                begin
                    // Shutdown abandons the conversion and frees the host
                    if (shutdown_reg)
                    begin
                        int_strobe_reg <= 1'b1;
                        int_state_reg <= INT_IDLE;
                    end
                    else if (sar_osc_step)
                    begin
                        int_cycle_reg <= '0;
                        int_bit_reg <= int_bit_reg - 4'h1;
                        if (int_bit_reg == '0)
                        begin
                            int_state_reg <= INT_FINISH;
                        end
                    end
                    else
                    begin
                        int_cycle_reg <= int_cycle_reg + 8'h01;
                    end
                end
                INT_FINISH:
                begin
                    int_result_reg <= dac_code_osc;
                    int_strobe_reg <= 1'b1;
                    int_state_reg <= INT_IDLE;
                end
                default:
                begin
                    int_state_reg <= INT_IDLE;
                end
            endcase
        end
    end

    sai_sar_engine #(
        .WIDTH(RESULT_WIDTH)
    ) u_sar_osc (
        .clk(clk),
        .rst_n(rst_n),
        .start(sar_osc_start),
        .step(sar_osc_step),
        .comp_high(comparator_high),
        .code(dac_code_osc)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign dout = dout_reg;
    assign dout_oe = dout_oe_reg;
    // Mode is static between control bytes, so the select never glitches
    assign conversion_strobe = mode_ext_reg ? ext_strobe_reg
        : int_strobe_reg;
    assign conversion_strobe_oe = strobe_oe_reg;
    assign device_shutdown = shutdown_reg;
    assign internal_compensation = int_comp_reg;
    assign sampler_track = track_reg;
    assign channel_select_bit2 = chan_reg[CH_MSB-CH_LSB];
    assign channel_select_bit1 = chan_reg[CH_MID-CH_LSB];
    assign channel_select_bit0 = chan_reg[0];
    assign polarity_select = pol_reg;
    assign input_type_select = type_reg;
    assign power_clock_mode_hi = mode_reg[MODE_MSB];
    assign power_clock_mode_lo = mode_reg[MODE_LSB];

endmodule // sai_serial_adc_interface

// ==== sim/sai_adc_monitor.sv ====
/* Port checker of the serial converter interface, bound to its top.
   Assumes the serial clock idles low between frames. */
module sai_adc_monitor (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conversion_strobe,
    input wire logic conversion_strobe_oe,
    input wire logic sampler_track,
    input wire logic power_clock_mode_hi,
    input wire logic power_clock_mode_lo,
    // Shutdown
    input wire logic [1:0] three_level_shutdown,
    input wire logic device_shutdown,
    input wire logic internal_compensation
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ext;
    assign ext = power_clock_mode_hi && power_clock_mode_lo;
    // *****
    // Sequences
    // *****
    sequence s_acq;
        sampler_track [*3] ##1 !sampler_track;
    endsequence
    sequence s_pulse;
        !sampler_track ##1 !conversion_strobe;
    endsequence
    // *****
    // Properties
    // *****
    // Enables pass a synchroniser, so six quiet samples are allowed
    property p_dout_float;
        @(posedge clk) disable iff (!rst_n) cs_n [*6] |-> !dout_oe;
    endproperty
    a_dout_float: assert property (p_dout_float) else $error("dout on");
    property p_strb_float;
        @(posedge clk) disable iff (!rst_n)
        (cs_n && ext) [*6] |-> !conversion_strobe_oe;
    endproperty
    a_strb_float: assert property (p_strb_float) else $error("sstb on");
    property p_dout_edge;
        @(posedge clk) disable iff (!rst_n) $changed(dout) |-> !sclk;
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("dout edge");
    property p_shut_low;
        @(posedge clk) disable iff (!rst_n)
        (three_level_shutdown == 2'h0) [*7] |-> device_shutdown;
    endproperty
    a_shut_low: assert property (p_shut_low) else $error("no sd");
    property p_comp_high;
        @(posedge clk) disable iff (!rst_n)
        three_level_shutdown[1] [*7] |-> internal_compensation;
    endproperty
    a_comp_high: assert property (p_comp_high) else $error("comp");
    property p_comp_float;
        @(posedge clk) disable iff (!rst_n) (three_level_shutdown == 2'h1)
        [*7] |-> !internal_compensation && !device_shutdown;
    endproperty
    a_comp_float: assert property (p_comp_float) else $error("flt");
    property p_acq;
        @(negedge sclk) disable iff (!rst_n || cs_n)
        $rose(sampler_track) |-> s_acq;
    endproperty
    a_acq: assert property (p_acq) else $error("track");
    property p_pulse;
        @(negedge sclk) disable iff (!rst_n || cs_n)
        conversion_strobe && ext |-> s_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe");
endmodule // sai_adc_monitor

bind sai_serial_adc_interface sai_adc_monitor i_mon (.clk, .rst_n, .sclk,
    .cs_n, .dout, .dout_oe, .conversion_strobe, .conversion_strobe_oe,
    .sampler_track, .power_clock_mode_hi, .power_clock_mode_lo,
    .three_level_shutdown, .device_shutdown, .internal_compensation);

// ==== sim/sai_host.sv ====
/* Host serial master model: sends a control byte, reads the result.
   Assumes the converter answers on falling serial clock edges. */
module sai_host (
    // Serial link
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic conversion_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import sai_pkg::*;
    logic strb_fell = 1'b0;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // 64 ns period at half duty; data is read just before a rise
    task automatic tick(input logic d, output logic q);
        din = d;
        #32 q = dout;
        sclk = 1'b1;
        #32 sclk = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, input int lead,
                        output logic [11:0] r);
        logic q;
        int i;
        #3.3 cs_n = 1'b0;
        #200;
        repeat (lead) tick(1'b0, q);
        for (i = 7; i >= 0; i--)
            tick(b[i], q);
        i = 0;
        // Ext mode: strobe stands high just after the hold edge
        #5 strb_fell = conversion_strobe;
        if (b[1:0] == MODE_INT_CLK)
        begin
            while (conversion_strobe && i < 40)
                #25 i++;
            strb_fell = !conversion_strobe;
            // No rising edge until the strobe is back high
            while (!conversion_strobe && i < 400)
                #25 i++;
        end
        r = '0;
        repeat (b[1] ? 13 : 1)
        begin
            tick(1'b0, q);
            r = {r[10:0], q};
        end
        #32 cs_n = 1'b1;
        #200;
    endtask
endmodule // sai_host

// ==== sim/sai_serial_adc_interface_tb_top.sv ====
/* Self-checking bench of the converter interface with a host model.
   Assumes an ideal front end that compares a held input code. */
module sai_serial_adc_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sai_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe;
    logic conversion_strobe, conversion_strobe_oe;
    logic [1:0] three_level_shutdown = 2'h1;
    logic device_shutdown, internal_compensation;
    logic comparator_high, sampler_track, polarity_select;
    logic channel_select_bit2, channel_select_bit1, channel_select_bit0;
    logic input_type_select, power_clock_mode_hi, power_clock_mode_lo;
    logic [11:0] dac_code_link, dac_code_osc, res, cfg_out, sd_out;
    logic [11:0] vin = 12'h000;
    logic [7:0] b;
    logic [31:0] r32;
    integer seed = 32'h5E1172FB;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    // *****
    // Design, host and front end
    // *****
    sai_serial_adc_interface i_dut (.clk, .rst_n, .sclk, .cs_n, .din,
        .dout, .dout_oe, .conversion_strobe, .conversion_strobe_oe,
        .three_level_shutdown, .device_shutdown, .internal_compensation,
        .comparator_high, .sampler_track, .channel_select_bit2,
        .channel_select_bit1, .channel_select_bit0, .polarity_select,
        .input_type_select, .power_clock_mode_hi, .power_clock_mode_lo,
        .dac_code_link, .dac_code_osc);
    // An undriven data line shows the inverse, so a late enable is seen
    wire dout_pin = dout_oe ? dout : ~dout;
    sai_host i_host (.sclk, .cs_n, .din, .dout(dout_pin), .conversion_strobe);
    // Half an LSB offset makes the search settle exactly on vin
    assign comparator_high = {vin, 1'b1} >
        {(power_clock_mode_lo ? dac_code_link : dac_code_osc), 1'b0};
    assign cfg_out = {5'h00, channel_select_bit2, channel_select_bit1,
        channel_select_bit0, polarity_select, input_type_select,
        power_clock_mode_hi, power_clock_mode_lo};
    assign sd_out = {10'h000, device_shutdown, internal_compensation};
    // *****
    // Checks and run control
    // *****
    function automatic logic [11:0] exp_cfg(input logic [7:0] c);
        return {5'h00, c[6:0]};
    endfunction
    function automatic logic [11:0] exp_sd(input logic [1:0] c);
        return {10'h000, c == SD_LEVEL_LOW, c[1]};
    endfunction
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            three_level_shutdown <= k[1:0];
            repeat (8) @(posedge clk);
            check(sd_out, exp_sd(k[1:0]));
        end
        // Modes cycle through all four codes; input extremes come first
        for (int k = 0; k < 16; k++)
        begin
            r32 = $random(seed);
            b = {1'b1, r32[6:2], k[1:0]};
            @(posedge clk);
            vin <= k < 8 ? {12{k[2] ^ k[0]}} : r32[27:16];
            @(posedge clk);
            i_host.xfer(b, k % 3, res);
            check(cfg_out, exp_cfg(b));
            if (b[1])
                check(res, vin);
            if (b[1])
                check({11'h000, i_host.strb_fell}, 12'h001);
        end
        close_out();
    end
endmodule // sai_serial_adc_interface_tb_top
